//--- mcs_chain.sv
// multiboard clock and sync chain: pin repeaters, channel clock select, sync fan-out
//
// Functional notes
// - decode three-bit slot switch; settings 0..3 valid, 4..7 select nothing
// - initiator sends internal sample clock out; target copies received clock
// - initiator sends software sync out; target repeats received sync
// - software bit selects TTL or LVDS signalling on clock and sync inputs
// - TTL uses positive lines only; negative outputs held inactive
// - software designates the board initiator or target
// - only software-selected channels take the external clock; others internal
// - on a target every channel answers a received sync pulse
// - a sync event starts all converters in the same cycle
// - every initiator sync pulse starts the board's synchronisation sequence
// - received sync may clear the input data buffers on targets
`timescale 1ns/1ns

module mcs_chain (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // register port
    input  wire logic [3:0]           addr,
    input  wire logic [31:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [31:0]          rdata,
    // slot switch
    input  wire logic [2:0]           slot_switch,
    output logic      [3:0]           slot_enable,
    // local rate generator
    input  wire logic                 int_sample_clk,
    // chain inputs
    input  wire logic                 chain_clock_in_pos,
    input  wire logic                 chain_clock_in_neg,
    input  wire logic                 chain_sync_in_pos,
    input  wire logic                 chain_sync_in_neg,
    // chain outputs
    output logic                      chain_clock_out_pos,
    output logic                      chain_clock_out_neg,
    output logic                      chain_sync_out_pos,
    output logic                      chain_sync_out_neg,
    // channel side
    output logic      [11:0]          chan_ext_clk_en,
    output logic      [11:0]          chan_clk,
    output logic      [11:0]          chan_sync_start,
    output logic                      buffer_clear
);
    typedef enum logic [1:0] {
        MCS_IDLE  = 2'b01,
        MCS_DRIVE = 2'b10
    } mcs_pulse_type;

    localparam int CNT_W_L = mcs_pkg::CNT_W;

    mcs_pulse_type          pulse_state;
    logic [3:0]             pulse_cnt;
    logic                   ctrl_init;
    logic                   ctrl_lvds;
    logic                   ctrl_clr;
    logic [11:0]            clksel;
    logic [CNT_W_L-1:0]     sync_count;
    logic                   sync_prev;
    logic [6:0]             pin_sync;
    logic                   rx_clk;
    logic                   rx_sync;
    logic                   target_rise;
    logic                   sw_cmd;
    logic                   sync_event;
    logic                   ctrl_wr;
    logic                   slot_ok;
    logic [3:0]             slot_dec;

    // slot decode, shared by status and the enable output
    function automatic logic [3:0] slot_decode(input logic [2:0] sel);
        logic [3:0] onehot;
        onehot = 4'h0;
        if (sel < 3'(mcs_pkg::SLOT_CFGS)) begin
            onehot[sel[1:0]] = 1'b1;
        end
        return onehot;
    endfunction

    mcs_sync_bits #(
        .W (7)
    ) u_pins (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .async_in ({slot_switch, chain_sync_in_neg, chain_sync_in_pos,
                    chain_clock_in_neg, chain_clock_in_pos}),
        .sync_out (pin_sync)
    );

    always_comb begin
        if (ctrl_lvds) begin
            rx_clk  = pin_sync[0] & ~pin_sync[1];
            rx_sync = pin_sync[2] & ~pin_sync[3];
        end else begin
            rx_clk  = pin_sync[0];
            rx_sync = pin_sync[2];
        end
    end

    assign slot_dec = slot_decode(pin_sync[6:4]);
    assign slot_ok  = |slot_dec;

    assign ctrl_wr = wr && (addr == mcs_pkg::REG_CTRL);
    assign sw_cmd  = ctrl_wr && wdata[mcs_pkg::CTRL_SYNC_BIT] && ctrl_init;

    assign target_rise = rx_sync && !sync_prev;

    assign sync_event = ctrl_init ? sw_cmd : target_rise;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= rx_sync;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_init <= mcs_pkg::CTRL_INIT_RESET;
            ctrl_lvds <= mcs_pkg::CTRL_LVDS_RESET;
            ctrl_clr  <= mcs_pkg::CTRL_CLR_RESET;
        end else if (ctrl_wr) begin
            ctrl_init <= wdata[mcs_pkg::CTRL_INIT_BIT];
            ctrl_lvds <= wdata[mcs_pkg::CTRL_LVDS_BIT];
            ctrl_clr  <= wdata[mcs_pkg::CTRL_CLR_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clksel <= mcs_pkg::CLKSEL_RESET;
        end else if (wr && (addr == mcs_pkg::REG_CLKSEL)) begin
            clksel <= wdata[11:0];
        end
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                mcs_pkg::REG_CTRL: begin
                    rdata <= {29'h0, ctrl_clr, ctrl_lvds, ctrl_init};
                end
                mcs_pkg::REG_CLKSEL: begin
                    rdata <= {20'h0, clksel};
                end
                mcs_pkg::REG_STATUS: begin
                    rdata <= {16'h0, sync_count, 1'b0, rx_sync, rx_clk, slot_ok, slot_dec};
                end
                default: begin
                    rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            slot_enable <= 4'h0;
        end else begin
            slot_enable <= slot_dec;
        end
    end

    // stretch so a downstream board sampling slowly still sees it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pulse_state <= MCS_IDLE;
            pulse_cnt   <= 4'h0;
        end else begin
            case (pulse_state)
                MCS_IDLE: begin
                    if (sw_cmd) begin
                        pulse_state <= MCS_DRIVE;
                        pulse_cnt   <= mcs_pkg::SYNC_PULSE_LOAD;
                    end
                end
                MCS_DRIVE: begin
                    if (sw_cmd) begin
                        pulse_cnt <= mcs_pkg::SYNC_PULSE_LOAD;
                    end else if (!ctrl_init || pulse_cnt == 4'h1) begin
                        pulse_state <= MCS_IDLE;
                        pulse_cnt   <= 4'h0;
                    end else begin
                        pulse_cnt <= pulse_cnt - 4'h1;
                    end
                end
                default: begin
                    pulse_state <= MCS_IDLE;
                    pulse_cnt   <= 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            chain_clock_out_pos <= 1'b0;
            chain_clock_out_neg <= 1'b0;
            chain_sync_out_pos  <= 1'b0;
            chain_sync_out_neg  <= 1'b0;
        end else begin
            chain_clock_out_pos <= ctrl_init ? int_sample_clk : rx_clk;
            chain_sync_out_pos  <= ctrl_init ? (sw_cmd || pulse_state == MCS_DRIVE) : rx_sync;
            chain_clock_out_neg <= ctrl_lvds && !(ctrl_init ? int_sample_clk : rx_clk);
            chain_sync_out_neg  <= ctrl_lvds &&
                                   !(ctrl_init ? (sw_cmd || pulse_state == MCS_DRIVE) : rx_sync);
        end
    end

    generate
        for (genvar i = 0; i < mcs_pkg::NUM_CHAN; i++) begin : g_chan
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    chan_clk[i]        <= 1'b0;
                    chan_ext_clk_en[i] <= 1'b0;
                end else begin
                    chan_clk[i]        <= clksel[i] ? rx_clk : int_sample_clk;
                    chan_ext_clk_en[i] <= clksel[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            chan_sync_start <= 12'h000;
            buffer_clear    <= 1'b0;
            sync_count      <= '0;
        end else begin
            chan_sync_start <= {12{sync_event}};
            buffer_clear    <= target_rise && !ctrl_init && ctrl_clr;
            if (sync_event) begin
                sync_count <= sync_count + 8'h01;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_sw_sync;
        sw_cmd && pulse_state == MCS_IDLE;
    endsequence

    sequence s_rx_rise;
        !ctrl_init && target_rise;
    endsequence

    a_slot_decode: assert property (
        (slot_enable != 4'h0) |-> ($onehot(slot_enable) && $past(pin_sync[6:4]) < 3'h4))
        else $error("slot enable not a valid decode");

    a_clk_repeat: assert property (
        (!ctrl_init && $past(!ctrl_init)) |=> chain_clock_out_pos == $past(rx_clk))
        else $error("target clock out is not a copy of clock in");

    a_sync_pulse_len: assert property (
        (s_sw_sync ##1 ctrl_init [*8]) |-> $past(chain_sync_out_pos, 7) && chain_sync_out_pos)
        else $error("initiator sync pulse too short");

    a_ttl_neg_idle: assert property (
        $past(!ctrl_lvds) |-> (!chain_clock_out_neg && !chain_sync_out_neg))
        else $error("negative output active in TTL");

    a_role_write: assert property (
        ctrl_wr |=> (ctrl_init == $past(wdata[0]) && ctrl_lvds == $past(wdata[1])))
        else $error("control write not taken");

    a_chan_select: assert property (
        (clksel[0] && $stable(clksel)) |=> chan_clk[0] == $past(rx_clk))
        else $error("selected channel not on external clock");

    a_all_channels: assert property (
        s_rx_rise |=> chan_sync_start == 12'hfff)
        else $error("not every channel got the sync");

    a_single_event: assert property (
        s_rx_rise |=> !target_rise ##1 chan_sync_start == 12'h000)
        else $error("one sync pulse gave two events");

    a_buffer_clear: assert property (
        buffer_clear |-> $past(ctrl_clr && !ctrl_init && target_rise))
        else $error("buffer clear without a target sync");
endmodule

//--- mcs_sync_bits.sv
// clock-chain constants package and the pin synchroniser module
`timescale 1ns/1ns

package mcs_pkg;
    localparam int          ADDR_W            = 4;
    localparam int          DATA_W            = 32;
    localparam int          NUM_CHAN          = 12;
    localparam int          SLOT_W            = 3;
    localparam int          SLOT_CFGS         = 4;
    localparam int          CNT_W             = 8;
    localparam int          PULSE_CNT_W       = 4;
    // register offsets
    localparam logic [3:0]  REG_CTRL          = 4'h0;
    localparam logic [3:0]  REG_CLKSEL        = 4'h4;
    localparam logic [3:0]  REG_STATUS        = 4'h8;
    // control register fields
    localparam int          CTRL_INIT_BIT     = 0;
    localparam int          CTRL_LVDS_BIT     = 1;
    localparam int          CTRL_CLR_BIT      = 2;
    localparam int          CTRL_SYNC_BIT     = 3;
    // status register fields
    localparam int          STAT_SLOT_LSB     = 0;
    localparam int          STAT_SLOT_OK_BIT  = 4;
    localparam int          STAT_CLK_BIT      = 5;
    localparam int          STAT_SYNC_BIT     = 6;
    localparam int          STAT_CNT_LSB      = 8;
    // values after reset
    localparam logic        CTRL_INIT_RESET   = 1'b0;
    localparam logic        CTRL_LVDS_RESET   = 1'b0;
    localparam logic        CTRL_CLR_RESET    = 1'b0;
    localparam logic [11:0] CLKSEL_RESET      = 12'h000;
    // sync pulse sent down the chain by an initiator
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          SYNC_PULSE_NS     = 100;
    localparam int          SYNC_PULSE_CYCLES =
        (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  SYNC_PULSE_LOAD   = 4'(SYNC_PULSE_CYCLES - 1);
endpackage

module mcs_sync_bits #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    // asynchronous inputs and their synchronised copies
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

//--- mcs_upstream_model.sv
// upstream clock and sync source that feeds the chain inputs
`timescale 1ns/1ns
module mcs_upstream_model (
    // timing and mode
    input  wire logic clk_sys,
    input  wire logic lvds,
    input  wire logic clk_run,
    input  wire logic sync_level,
    // chain pins
    output logic      clk_pos,
    output logic      clk_neg,
    output logic      sync_pos,
    output logic      sync_neg
);
    logic open_pat = 1'b0;
    // open lines float, so show a moving pattern rather than a stale level
    always @(posedge clk_sys) open_pat <= ~open_pat;
    // 160 ns link clock, offset from system edges; stands low while clk_run is low
    initial begin
        clk_pos = 1'b0;
        #3;
        forever begin
            #80;
            clk_pos = clk_run ? ~clk_pos : 1'b0;
        end
    end
    assign sync_pos = sync_level;
    assign clk_neg  = lvds ? ~clk_pos : open_pat;
    assign sync_neg = lvds ? ~sync_pos : ~open_pat;
endmodule

//--- mcs_chain_tb.sv
// self-checking bench for the clock and sync chain block
`timescale 1ns/1ns
module mcs_chain_tb;
    typedef struct packed {logic [2:0] slot; logic [3:0] en;} mcs_row_type;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        int_sample_clk = 1'b0;
    logic [2:0]  slot_switch = 3'h0;
    logic        lvds = 1'b0;
    logic        clk_run = 1'b0;
    logic        sync_level = 1'b0;
    logic        chain_clock_in_pos, chain_clock_in_neg, chain_sync_in_pos, chain_sync_in_neg;
    logic        chain_clock_out_pos, chain_clock_out_neg, chain_sync_out_pos;
    logic        chain_sync_out_neg, buffer_clear;
    logic [3:0]  slot_enable;
    logic [11:0] chan_ext_clk_en, chan_clk, chan_sync_start;
    int          err_count = 0, checks_done = 0, cycles = 0, pulses, clr, hi;
    mcs_row_type rows [8] = '{'{3'h0, 4'h1}, '{3'h1, 4'h2}, '{3'h2, 4'h4}, '{3'h3, 4'h8},
                              '{3'h4, 4'h0}, '{3'h5, 4'h0}, '{3'h6, 4'h0}, '{3'h7, 4'h0}};

    mcs_chain uut (.clk_sys, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .slot_switch,
        .slot_enable, .int_sample_clk, .chain_clock_in_pos, .chain_clock_in_neg,
        .chain_sync_in_pos, .chain_sync_in_neg, .chain_clock_out_pos, .chain_clock_out_neg,
        .chain_sync_out_pos, .chain_sync_out_neg, .chan_ext_clk_en, .chan_clk,
        .chan_sync_start, .buffer_clear);
    mcs_upstream_model src (.clk_sys, .lvds, .clk_run, .sync_level,
        .clk_pos(chain_clock_in_pos), .clk_neg(chain_clock_in_neg),
        .sync_pos(chain_sync_in_pos), .sync_neg(chain_sync_in_neg));

    always #5 clk_sys = ~clk_sys;

    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // starts right after an edge, so the first sample is the cycle after it
    task automatic watch(input int n);
        repeat (n) begin
            #1;
            if (chan_sync_start === 12'hfff) pulses++;
            if (buffer_clear === 1'b1) clr++;
            if (chain_sync_out_pos === 1'b1) hi++;
            @(posedge clk_sys);
        end
    endtask

    task automatic rx_pulse(input int n);
        pulses = 0;
        clr = 0;
        hi = 0;
        repeat (n) begin
            sync_level <= 1'b1;
            watch(5);
            sync_level <= 1'b0;
            watch(8);
        end
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        #1 chk(32'({chain_clock_out_pos, chain_sync_out_pos, chan_sync_start}), 32'h0);
        rst_b <= 1'b1;
        reg_rd(4'h0, d);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            slot_switch <= rows[i].slot;
            repeat (4) @(posedge clk_sys);
            #1 chk(32'(slot_enable), 32'(rows[i].en));
            reg_rd(4'h8, d);
            chk(32'(d[4:0]), 32'({rows[i].en != 4'h0, rows[i].en}));
        end
        reg_wr(4'h4, 32'hfffffa5a);
        reg_wr(4'hc, 32'hffffffff);
        reg_rd(4'hc, d);
        chk(d, 32'h0);
        reg_rd(4'h4, d);
        chk(d, 32'h00000a5a);
        chk(32'(chan_ext_clk_en), 32'ha5a);
        clk_run <= 1'b1;
        @(posedge chain_clock_in_pos);
        repeat (4) @(posedge clk_sys);
        #1 chk(32'(chan_clk), 32'ha5a);
        chk(32'({chain_clock_out_pos, chain_clock_out_neg, chain_sync_out_neg}), 32'h4);
        int_sample_clk <= 1'b1;
        @(negedge chain_clock_in_pos);
        repeat (4) @(posedge clk_sys);
        #1 chk(32'(chan_clk), 32'h5a5);
        chk(32'(chain_clock_out_pos), 32'h0);
        reg_wr(4'h0, 32'h2);
        lvds <= 1'b1;
        repeat (3) @(posedge clk_sys);
        repeat (24) begin
            @(posedge clk_sys);
            #1 chk(32'(chain_clock_out_neg), 32'(!chain_clock_out_pos));
            chk(32'(chain_sync_out_neg), 32'(!chain_sync_out_pos));
        end
        clk_run <= 1'b0;
        lvds <= 1'b0;
        reg_wr(4'h0, 32'h4);
        rx_pulse(2);
        chk(32'(pulses), 32'h2);
        chk(32'(clr), 32'h2);
        chk(32'(hi), 32'ha);
        reg_rd(4'h8, d);
        chk(32'(d[15:8]), 32'h2);
        reg_wr(4'h0, 32'h1);
        rx_pulse(1);
        chk(32'({pulses[3:0], hi[3:0]}), 32'h0);
        pulses = 0;
        clr = 0;
        hi = 0;
        reg_wr(4'h0, 32'h9);
        watch(14);
        chk(32'(pulses), 32'h1);
        chk(32'(hi), 32'ha);
        chk(32'(clr), 32'h0);
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(chain_clock_out_pos), 32'h1);
        int_sample_clk <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk(32'(chain_clock_out_pos), 32'h0);
        report_and_stop;
    end
endmodule
